// File: verilog/core_reset_seq.sv
// Reset sequencer for a serial-link hard core and its transceivers.
// How it works
// - Hard or soft controller chosen by a build-time parameter.
// - Combined power-on reset asserted when board pin or application request asserted.
// - Hard controller resets the core straight from the board pin.
// - Soft controller resets the core from board pin or combined reset.
// - Soft controller waits for user-clock-in-use after reset release.
// - Configuration and core resets release 32 cycles after clock-in-use.
// - Reset indicator to the application drops after internal resets release.
// - Detect.Quiet to Detect.Active needs reconfig not busy and RX PLL locked.
// - Receiver detect done on status pulse with receive status equal 3.
// - After receiver detect, training moves Detect.Active to Polling.Active.
// - RX digital reset held until Polling; release after signal detect stable 3 ms.
// - Serializer reset released once combined reset deasserts.
// - TX digital reset released after TX PLL lock stable 127 cycles.
// - Timeout flag set if the sequence is not done within the 100 ms configuration time.
`timescale 1ns/10ps
`default_nettype none
module core_reset_seq
    import rst_seq_pkg::*;
#(
    parameter bit SOFT_CTRL = 1'b1,
    parameter int unsigned SIGDET_CNT = SIGDET_CYCLES,
    parameter int unsigned CFG_CNT = CFG_TIME_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Reset sources
    input wire logic board_rst_n,
    input wire logic app_req_rst_n,
    input wire logic clk_inuse,
    // Transceiver status
    input wire logic reconfig_busy,
    input wire logic rx_pll_locked,
    input wire logic tx_pll_locked,
    input wire logic phy_status,
    input wire logic [2:0] rx_status,
    input wire logic rx_sig_detect,
    // Reset outputs
    output logic por_n,
    output logic core_rst_n,
    output logic cfg_rst,
    output logic soft_rst,
    output logic reset_status,
    output logic serdes_rst_n,
    output logic rx_digital_rst,
    output logic tx_digital_rst,
    // Status outputs
    output logic [1:0] lt_state,
    output logic seq_done,
    output logic cfg_timeout
);
    // ------------------------------------------------------------
    // Power-on reset and core reset
    // ------------------------------------------------------------
    logic por_n_reg;
    logic core_rst_n_reg;
    logic por_n_next;
    logic core_rst_n_next;

    // Either source low pulls the combined reset low.
    assign por_n_next = board_rst_n & app_req_rst_n;
    // Hard path follows the pin; soft path also follows the combined reset.
    assign core_rst_n_next = SOFT_CTRL ? por_n_next : board_rst_n;

    // Registered reset sources.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_n_reg <= 1'b0;
            core_rst_n_reg <= 1'b0;
        end else begin
            por_n_reg <= por_n_next;
            core_rst_n_reg <= core_rst_n_next;
        end
    end

    // ------------------------------------------------------------
    // Internal core reset release
    // ------------------------------------------------------------
    logic [5:0] rel_cnt_reg;
    logic [5:0] rel_cnt_next;
    logic core_rst_reg;
    logic core_rst_next;
    logic reset_status_reg;
    logic in_reset;
    logic rel_done;

    // Combined reset or core reset restarts the whole release path.
    assign in_reset = !por_n_reg || !core_rst_n_reg;
    assign rel_done = (rel_cnt_reg == 6'(RELEASE_CYCLES - 1));
    // Count only while the user clock is reported in use.
    assign rel_cnt_next = (in_reset || !clk_inuse) ? 6'h00
                        : (rel_done ? rel_cnt_reg : rel_cnt_reg + 6'h01);
    assign core_rst_next = in_reset ? 1'b1 : (rel_done && clk_inuse ? 1'b0 : core_rst_reg);

    // Release counter, internal resets and indicator.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rel_cnt_reg <= 6'h00;
            core_rst_reg <= 1'b1;
            reset_status_reg <= 1'b1;
        end else begin
            rel_cnt_reg <= rel_cnt_next;
            core_rst_reg <= core_rst_next;
            reset_status_reg <= in_reset || core_rst_reg;
        end
    end

    // ------------------------------------------------------------
    // Link training detect and polling
    // ------------------------------------------------------------
    lt_state_t lt_reg;
    lt_state_t lt_next;
    logic rx_rst_reg;
    logic rx_rst_next;
    logic detect_ok;
    stable_if sigdet_bus ();

    // Receiver detect completes on the status pulse with the detected code.
    assign detect_ok = phy_status && (rx_status == RXSTAT_DETECTED);

    // Next training state.
    always_comb begin
        lt_next = lt_reg;
        unique case (lt_reg)
            LT_DETECT_QUIET: begin
                if (!reconfig_busy && rx_pll_locked) begin
                    lt_next = LT_DETECT_ACTIVE;
                end
            end
            LT_DETECT_ACTIVE: begin
                if (detect_ok) begin
                    lt_next = LT_POLLING_ACTIVE;
                end
            end
            LT_POLLING_ACTIVE: begin
                lt_next = LT_POLLING_ACTIVE;
            end
            default: begin
                lt_next = LT_DETECT_QUIET;
            end
        endcase
    end

    assign sigdet_bus.level = rx_sig_detect && (lt_reg == LT_POLLING_ACTIVE);
    // Held in reset until polling, then released once detect is stable.
    assign rx_rst_next = (lt_reg != LT_POLLING_ACTIVE) || (!sigdet_bus.stable && rx_rst_reg);

    // Signal-detect stability timer.
    stable_timer #(
        .LIMIT(CNT_W'(SIGDET_CNT))
    ) u_sigdet (
        .clk(clk),
        .rst_n(rst_n),
        .clr(in_reset),
        .sig(sigdet_bus)
    );

    // Training state and receive reset.
    always_ff @(posedge clk) begin
        if (!rst_n || in_reset) begin
            lt_reg <= LT_DETECT_QUIET;
            rx_rst_reg <= 1'b1;
        end else begin
            lt_reg <= lt_next;
            rx_rst_reg <= rx_rst_next;
        end
    end

    // ------------------------------------------------------------
    // Transmit path resets
    // ------------------------------------------------------------
    logic [7:0] pll_cnt_reg;
    logic tx_rst_reg;
    logic serdes_n_reg;
    logic pll_stable;

    assign pll_stable = (pll_cnt_reg >= 8'(PLL_STABLE_CYCLES));

    // Lock stability count and transmit resets.
    always_ff @(posedge clk) begin
        if (!rst_n || !por_n_reg) begin
            pll_cnt_reg <= 8'h00;
            tx_rst_reg <= 1'b1;
            serdes_n_reg <= 1'b0;
        end else begin
            serdes_n_reg <= 1'b1;
            pll_cnt_reg <= !tx_pll_locked ? 8'h00 : (pll_stable ? pll_cnt_reg : pll_cnt_reg + 8'h01);
            tx_rst_reg <= tx_rst_reg && !pll_stable;
        end
    end

    // ------------------------------------------------------------
    // Configuration-time watchdog
    // ------------------------------------------------------------
    logic [23:0] cfg_cnt_reg;
    logic done_reg;
    logic cfg_to_reg;
    logic all_done;

    assign all_done = !reset_status_reg && !rx_rst_reg && !tx_rst_reg;

    // Flags a sequence that overruns the configuration time.
    always_ff @(posedge clk) begin
        if (!rst_n || !por_n_reg) begin
            cfg_cnt_reg <= 24'h000000;
            done_reg <= 1'b0;
            cfg_to_reg <= 1'b0;
        end else begin
            done_reg <= all_done;
            if (!all_done && cfg_cnt_reg < 24'(CFG_CNT)) begin
                cfg_cnt_reg <= cfg_cnt_reg + 24'h000001;
            end
            cfg_to_reg <= cfg_to_reg || (!all_done && cfg_cnt_reg >= 24'(CFG_CNT));
        end
    end

    // Outputs straight from flip-flops.
    assign por_n = por_n_reg;
    assign core_rst_n = core_rst_n_reg;
    assign cfg_rst = core_rst_reg;
    assign soft_rst = core_rst_reg;
    assign reset_status = reset_status_reg;
    assign serdes_rst_n = serdes_n_reg;
    assign rx_digital_rst = rx_rst_reg;
    assign tx_digital_rst = tx_rst_reg;
    assign lt_state = lt_reg;
    assign seq_done = done_reg;
    assign cfg_timeout = cfg_to_reg;
endmodule : core_reset_seq
`default_nettype wire

// File: verilog/rst_seq_pkg.sv
// Package of constants and types for the core reset sequencer.
package rst_seq_pkg;
    // ------------------------------------------------------------
    // Clock and timing constants
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned RELEASE_CYCLES = 32;
    localparam int unsigned SIGDET_MS = 3;
    localparam int unsigned SIGDET_CYCLES = (CLK_HZ / 1000) * SIGDET_MS;
    localparam int unsigned PLL_STABLE_CYCLES = 127;
    localparam int unsigned CFG_TIME_MS = 100;
    localparam int unsigned CFG_TIME_CYCLES = (CLK_HZ / 1000) * CFG_TIME_MS;
    localparam int CNT_W = 24;
    // ------------------------------------------------------------
    // Receiver detect encoding
    // ------------------------------------------------------------
    localparam logic [2:0] RXSTAT_DETECTED = 3'h3;
    // ------------------------------------------------------------
    // Link training states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LT_DETECT_QUIET = 2'b00,
        LT_DETECT_ACTIVE = 2'b01,
        LT_POLLING_ACTIVE = 2'b10
    } lt_state_t;
    // Stable-count step: counts while the level holds, restarts otherwise.
    function automatic logic [CNT_W-1:0] stable_step(input logic level, input logic [CNT_W-1:0] cnt,
                                                     input logic [CNT_W-1:0] limit);
        logic [CNT_W-1:0] r;
        r = '0;
        if (level) begin
            r = (cnt >= limit) ? limit : cnt + CNT_W'(1);
        end
        return r;
    endfunction : stable_step
endpackage : rst_seq_pkg

// File: verilog/stable_if.sv
// Interface carrying a level and its stable indication between modules.
`timescale 1ns/10ps
`default_nettype none
interface stable_if;
    logic level;
    logic stable;
    modport owner (output level, input stable);
    modport timer (input level, output stable);
endinterface : stable_if
`default_nettype wire

// File: verilog/stable_timer.sv
// Timer that flags a level held high for a given number of cycles.
`timescale 1ns/10ps
`default_nettype none
module stable_timer
    import rst_seq_pkg::*;
#(
    parameter logic [CNT_W-1:0] LIMIT = CNT_W'(1)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    // Level and result
    stable_if.timer sig
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // Next count restarts whenever the level drops or a clear arrives.
    assign cnt_next = clr ? '0 : stable_step(sig.level, cnt_reg, LIMIT);
    assign sig.stable = (cnt_reg >= LIMIT);

    // Counter register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : stable_timer
`default_nettype wire

// File: sim/core_reset_seq_assertions.sv
// Concurrent checks on the ports of the core reset sequencer.
`timescale 1ns/10ps
`default_nettype none
module core_reset_seq_assertions
    import rst_seq_pkg::*;
#(parameter bit SOFT_CTRL = 1'b1, parameter int unsigned SIGDET_CNT = 20, parameter int unsigned CFG_CNT = 2000) (
    // Clock, reset and reset sources
    input wire logic clk, rst_n, board_rst_n, app_req_rst_n, clk_inuse,
    // Transceiver status
    input wire logic reconfig_busy, rx_pll_locked, tx_pll_locked, phy_status, rx_sig_detect,
    input wire logic [2:0] rx_status,
    // Reset outputs and training state
    input wire logic por_n, core_rst_n, cfg_rst, soft_rst, reset_status, serdes_rst_n, rx_digital_rst, tx_digital_rst,
    input wire logic [1:0] lt_state
);
    // ------------------------------------------------------------
    // Run-length helpers and checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] use_run;
    logic [7:0] lock_run;
    logic [23:0] sd_run;
    // Counts how long clock-in-use, transmit lock and signal detect have held.
    always_ff @(posedge clk) begin
        use_run <= (rst_n && por_n && clk_inuse) ? use_run + 8'h01 : 8'h00;
        lock_run <= (rst_n && por_n && tx_pll_locked) ? lock_run + 8'h01 : 8'h00;
        sd_run <= (rst_n && rx_sig_detect && lt_state == LT_POLLING_ACTIVE) ? sd_run + 24'h1 : 24'h0;
    end
    a_por_combine: assert property (!(board_rst_n && app_req_rst_n) |=> !por_n)
        else $error("combined reset stayed high with a source active");
    a_core_pin: assert property (!board_rst_n |=> !core_rst_n)
        else $error("core reset not taken from the board pin");
    a_cfg_wait: assert property ($fell(cfg_rst) |-> use_run >= 8'd32)
        else $error("core resets released too early");
    a_cfg_bound: assert property (use_run == 8'd40 |-> !cfg_rst && !soft_rst)
        else $error("core resets released too late");
    a_status_hold: assert property (!reset_status |-> !cfg_rst && !soft_rst && $past(por_n))
        else $error("indicator low while a core reset is held");
    a_status_por: assert property (!por_n |=> reset_status)
        else $error("indicator not reasserted by combined reset");
    a_quiet_hold: assert property (lt_state == LT_DETECT_QUIET && (reconfig_busy || !rx_pll_locked)
        |=> lt_state == LT_DETECT_QUIET)
        else $error("left quiet detect without lock");
    a_detect_gate: assert property (lt_state == LT_DETECT_ACTIVE && !(phy_status && rx_status == RXSTAT_DETECTED)
        |=> lt_state != LT_POLLING_ACTIVE)
        else $error("polling entered without a receiver found");
    a_rx_release: assert property ($fell(rx_digital_rst) |-> sd_run >= SIGDET_CNT - 1)
        else $error("receive reset released before detect was stable");
    a_serdes_por: assert property (!por_n |=> !serdes_rst_n)
        else $error("serializer reset released under combined reset");
    a_tx_release: assert property ($fell(tx_digital_rst) |-> lock_run >= 8'd127)
        else $error("transmit reset released before lock was stable");
    c_polling: cover property (lt_state == LT_POLLING_ACTIVE && !rx_digital_rst);
    c_status: cover property ($fell(reset_status));
    c_tx: cover property ($fell(tx_digital_rst));
endmodule : core_reset_seq_assertions
bind core_reset_seq core_reset_seq_assertions #(.SOFT_CTRL(SOFT_CTRL), .SIGDET_CNT(SIGDET_CNT), .CFG_CNT(CFG_CNT))
    i_chk (.*);
`default_nettype wire

// File: sim/xcvr_app_model.sv
// Behavioural transceiver and application partner of the sequencer.
`timescale 1ns/10ps
`default_nettype none
module xcvr_app_model (
    // Clock, bench controls and sequencer outputs
    input wire logic clk, go, sig, por_n, reset_status,
    input wire logic [2:0] det_code,
    input wire logic [1:0] lt_state,
    // Transceiver status and application reset
    output logic reconfig_busy, rx_pll_locked, tx_pll_locked, phy_status, rx_sig_detect,
    output logic [2:0] rx_status,
    output logic app_rst_n
);
    // ------------------------------------------------------------
    // Link status and application reset
    // ------------------------------------------------------------
    logic [2:0] det_cnt;
    logic [5:0] app_cnt;
    // Reconfiguration ends and both PLLs lock once the bench lets the link up.
    assign reconfig_busy = !go;
    assign rx_pll_locked = go;
    assign tx_pll_locked = go;
    assign rx_sig_detect = go && sig;
    // One status pulse every eight cycles in active detect; idle status is never the found code.
    assign phy_status = (lt_state == 2'h1) && (det_cnt == 3'h7);
    assign rx_status = phy_status ? det_code : ~det_code;
    // The application reset follows the combined reset and lifts 32 cycles after the indicator.
    assign app_rst_n = (app_cnt == 6'h20);
    always_ff @(posedge clk) begin
        det_cnt <= (lt_state == 2'h1) ? det_cnt + 3'h1 : 3'h0;
        app_cnt <= (!por_n || reset_status) ? 6'h00 : app_cnt + {5'h00, app_cnt != 6'h20};
    end
endmodule : xcvr_app_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the core reset sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rst_seq_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, partner and checks
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, board_rst_n = 1'b0, app_req_rst_n = 1'b1, clk_inuse = 1'b0;
    logic go = 1'b0, sig = 1'b0;
    logic [2:0] det_code = 3'h2;
    logic reconfig_busy, rx_pll_locked, tx_pll_locked, phy_status, rx_sig_detect, app_rst_n;
    logic [2:0] rx_status;
    logic por_n, core_rst_n, cfg_rst, soft_rst, reset_status, serdes_rst_n, rx_digital_rst, tx_digital_rst;
    logic seq_done, cfg_timeout;
    logic hard_core_rst_n;
    logic [1:0] lt_state;
    logic [7:0] mon;
    int n_fail = 0, checked = 0, k;
    // Watched bits: release flags, training state and completion.
    assign mon = {seq_done, por_n, lt_state, rx_digital_rst, tx_digital_rst, reset_status, cfg_rst};
    // The clock toggles every half period of 10 ns.
    always #10 clk = ~clk;
    core_reset_seq #(.SIGDET_CNT(20), .CFG_CNT(2000)) i_dut (.*);
    // A second sequencer built with the hard controller shares every input.
    core_reset_seq #(.SOFT_CTRL(1'b0), .SIGDET_CNT(20), .CFG_CNT(2000)) i_dut_hard (
        .clk(clk),
        .rst_n(rst_n),
        .board_rst_n(board_rst_n),
        .app_req_rst_n(app_req_rst_n),
        .clk_inuse(clk_inuse),
        .reconfig_busy(reconfig_busy),
        .rx_pll_locked(rx_pll_locked),
        .tx_pll_locked(tx_pll_locked),
        .phy_status(phy_status),
        .rx_status(rx_status),
        .rx_sig_detect(rx_sig_detect),
        .por_n(),
        .core_rst_n(hard_core_rst_n),
        .cfg_rst(),
        .soft_rst(),
        .reset_status(),
        .serdes_rst_n(),
        .rx_digital_rst(),
        .tx_digital_rst(),
        .lt_state(),
        .seq_done(),
        .cfg_timeout()
    );
    xcvr_app_model i_model (.*);
    // Compares one value and counts the result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Counts edges until a watched bit reaches a level, within a limit.
    task automatic wait_bit(input int b, input logic v, input int lim);
        #1;
        k = 0;
        while (mon[b] !== v && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask : wait_bit
    // Prints the counts and the verdict, then stops.
    task automatic print_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // Main sequence of tests.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({4'h0, por_n, core_rst_n, serdes_rst_n, reset_status}, 8'h01);
        chk({7'h00, hard_core_rst_n}, 8'h00);
        @(posedge clk);
        board_rst_n <= 1'b1;
        repeat (50) @(posedge clk);
        #1;
        chk({4'h0, por_n, core_rst_n, serdes_rst_n, cfg_rst}, 8'h0F);
        chk({6'h00, lt_state}, 8'h00);
        $display("test pin release done");
        @(posedge clk);
        clk_inuse <= 1'b1;
        repeat (20) @(posedge clk);
        clk_inuse <= 1'b0;
        @(posedge clk);
        clk_inuse <= 1'b1;
        wait_bit(0, 1'b0, 60);
        chk({7'h00, k >= 32 && k <= 34}, 8'h01);
        wait_bit(1, 1'b0, 4);
        chk({6'h00, k == 1, soft_rst}, 8'h02);
        $display("test core release done");
        @(posedge clk);
        go <= 1'b1;
        wait_bit(4, 1'b1, 4);
        chk(8'(k), 8'h01);
        wait_bit(2, 1'b0, 200);
        chk({7'h00, k >= 127 && k <= 129}, 8'h01);
        chk({6'h00, lt_state}, 8'h01);
        $display("test transmit and detect done");
        @(posedge clk);
        det_code <= 3'h3;
        wait_bit(5, 1'b1, 12);
        chk({6'h00, lt_state}, 8'h02);
        chk({7'h00, rx_digital_rst}, 8'h01);
        @(posedge clk);
        sig <= 1'b1;
        repeat (8) @(posedge clk);
        sig <= 1'b0;
        @(posedge clk);
        sig <= 1'b1;
        wait_bit(3, 1'b0, 40);
        chk({7'h00, k >= 20 && k <= 23}, 8'h01);
        wait_bit(7, 1'b1, 3);
        chk({6'h00, seq_done, cfg_timeout}, 8'h02);
        $display("test receive release done");
        @(posedge clk);
        app_req_rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        app_req_rst_n <= 1'b1;
        #1;
        chk({4'h0, por_n, reset_status, rx_digital_rst, app_rst_n}, 8'h06);
        chk({6'h00, core_rst_n, hard_core_rst_n}, 8'h01);
        chk({6'h00, lt_state}, 8'h00);
        wait_bit(1, 1'b0, 60);
        chk({7'h00, k >= 33 && k <= 37}, 8'h01);
        $display("test application request done");
        print_verdict();
    end
    // Cuts a hung run short well past the expected length of the tests.
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
